/* lock_status_pkg.sv */
// Constants shared by the lock status and write protect block
`default_nettype none
package lock_status_pkg;
  localparam int ADDR_W = 13;
  localparam logic [12:0] OFS_INPUT_STATUS = 13'h0184;
  localparam logic [12:0] OFS_DAC_LOW      = 13'h0185;
  localparam logic [12:0] OFS_HOLDOVER     = 13'h0188;
  localparam logic [12:0] OFS_KEY_HIGH     = 13'h1ffd;
  localparam logic [12:0] OFS_KEY_MID      = 13'h1ffe;
  localparam logic [12:0] OFS_KEY_LOW      = 13'h1fff;
  localparam int BIT_IN0_LOSS  = 0;
  localparam int BIT_IN1_LOSS  = 1;
  localparam int BIT_HOLDOVER  = 4;
  localparam int DAC_HI_LSB    = 6;
  localparam logic [9:0] DAC_RESET     = 10'h0200;
  localparam logic [7:0] KEY_HIGH_RESET = 8'h00;
  localparam logic [7:0] KEY_MID_RESET  = 8'h00;
  localparam logic [7:0] KEY_LOW_RESET  = 8'h53;
  localparam logic [7:0] KEY_LOW_OPEN   = 8'h53;
  localparam int CNT_W = 16;
  localparam int WND_W = 8;
endpackage
`default_nettype wire

/* lock_counter.sv */
// Digital lock detector counting in-window phase-detector cycles
`timescale 1ns/10ps
`default_nettype none
module lock_counter
  import lock_status_pkg::*;
#(
  parameter int CW = CNT_W,
  parameter int WW = WND_W
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          pd_event,
  input  wire logic [WW-1:0] phase_error,
  input  wire logic [WW-1:0] window_size,
  input  wire logic [CW-1:0] lock_count,
  output logic               lock_event,
  output logic [CW-1:0]      count_reg
);
  logic in_window;

  assign in_window  = phase_error < window_size;
  // One extra bit so a saturated count still meets its target
  assign lock_event = pd_event && in_window && (({1'b0, count_reg} + 1'b1) >= {1'b0, lock_count});

  // Count consecutive good cycles, clear on any outside edge pair
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_reg <= '0;
    end else if (pd_event) begin
      if (!in_window) begin
        count_reg <= '0;
      end else if (count_reg != {CW{1'b1}}) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  a_count_clear: assert property (@(posedge core_clk) disable iff (reset)
    pd_event && !in_window |=> count_reg == '0)
    else $error("count not cleared outside window");
endmodule
`default_nettype wire

/* lock_status_top.sv */
// Status readback, write protect key and digital lock detection
// Functional notes
// - Status bit 1 mirrors the input one signal loss condition.
// - Status bit 0 mirrors the input zero signal loss condition, bit 2 reads zero.
// - The 10-bit tuning DAC readback is split over status bits 7:6 and the next register.
// - The DAC readback is 512 after reset and may change once the first loop locks.
// - Holdover status bit 4 is high while in holdover, other bits read zero.
// - While locked every write is refused except to the three key registers.
// - The key registers are write only and read back as zero.
// - Unlock needs both high and middle key bytes at zero.
// - Unlock also needs the low key byte at 83, its reset value.
// - A lock event needs lock count cycles each with edges inside the window.
// - An edge pair outside the window clears the accumulated count.
// - A loop's lock indicator is raised on its lock event.
// - The first loop uses its window and count, the second loop its own pair.
// - Holdover exit is detected on the first loop with the exit count and ends holdover.
`timescale 1ns/10ps
`default_nettype none
module lock_status_top
  import lock_status_pkg::*;
#(
  parameter int CW = CNT_W,
  parameter int WW = WND_W
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  output logic                   reg_ack,
  output logic                   wr_accept,
  output logic                   regs_unlocked,
  input  wire logic              in0_signal_loss_pin,
  input  wire logic              in1_signal_loss_pin,
  input  wire logic              ref_pd_event,
  input  wire logic [WW-1:0]     ref_phase_error,
  input  wire logic              main_pd_event,
  input  wire logic [WW-1:0]     main_phase_error,
  input  wire logic [WW-1:0]     ref_loop_window_size,
  input  wire logic [CW-1:0]     ref_loop_lock_count,
  input  wire logic [WW-1:0]     main_loop_window_size,
  input  wire logic [CW-1:0]     main_loop_lock_count,
  input  wire logic [CW-1:0]     holdover_exit_count,
  input  wire logic              holdover_enter,
  input  wire logic              dac_update,
  input  wire logic [9:0]        dac_value,
  output logic                   first_loop_lock,
  output logic                   second_loop_lock,
  output logic                   holdover_state_flag,
  output logic                   protected_wr,
  output logic [7:0]             protected_wdata,
  output logic [ADDR_W-1:0]      protected_addr
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] los0_sync_reg;
  logic [1:0] los1_sync_reg;
  logic       in0_signal_loss_flag;
  logic       in1_signal_loss_flag;

  // Two stages per asynchronous loss pin
  always_ff @(posedge core_clk) begin
    if (reset) begin
      los0_sync_reg <= 2'h0;
      los1_sync_reg <= 2'h0;
    end else begin
      los0_sync_reg <= {los0_sync_reg[0], in0_signal_loss_pin};
      los1_sync_reg <= {los1_sync_reg[0], in1_signal_loss_pin};
    end
  end
  assign in0_signal_loss_flag = los0_sync_reg[1];
  assign in1_signal_loss_flag = los1_sync_reg[1];

  // ---------------------------------------------------------------
  // Write protect key
  // ---------------------------------------------------------------
  logic [7:0] key_high_reg;
  logic [7:0] key_mid_reg;
  logic [7:0] key_low_reg;
  logic       is_key_addr;

  function automatic logic key_addr(input logic [ADDR_W-1:0] a);
    key_addr = (a == OFS_KEY_HIGH) || (a == OFS_KEY_MID) || (a == OFS_KEY_LOW);
  endfunction

  assign is_key_addr   = key_addr(reg_addr);
  assign regs_unlocked = (key_high_reg == 8'h00) && (key_mid_reg == 8'h00)
                         && (key_low_reg == KEY_LOW_OPEN);
  assign wr_accept     = reg_wr && (is_key_addr || regs_unlocked);

  // Key bytes are always writable; host keeps them in order
  always_ff @(posedge core_clk) begin
    if (reset) begin
      key_high_reg <= KEY_HIGH_RESET;
      key_mid_reg  <= KEY_MID_RESET;
      key_low_reg  <= KEY_LOW_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_KEY_HIGH) key_high_reg <= reg_wdata;
      if (reg_addr == OFS_KEY_MID)  key_mid_reg  <= reg_wdata;
      if (reg_addr == OFS_KEY_LOW)  key_low_reg  <= reg_wdata;
    end
  end

  // Accepted writes to other registers leave for the rest of the device
  always_ff @(posedge core_clk) begin
    if (reset) begin
      protected_wr    <= 1'b0;
      protected_wdata <= 8'h00;
      protected_addr  <= '0;
    end else begin
      protected_wr <= wr_accept && !is_key_addr;
      if (wr_accept && !is_key_addr) begin
        protected_wdata <= reg_wdata;
        protected_addr  <= reg_addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // Lock detectors
  // ---------------------------------------------------------------
  logic          ref_lock_event;
  logic          main_lock_event;
  logic          exit_event;
  logic [CW-1:0] ref_cnt;
  logic [CW-1:0] main_cnt;
  logic [CW-1:0] exit_cnt;

  lock_counter #(.CW(CW), .WW(WW)) u_ref_lock (
    .core_clk    (core_clk),
    .reset       (reset),
    .pd_event    (ref_pd_event),
    .phase_error (ref_phase_error),
    .window_size (ref_loop_window_size),
    .lock_count  (ref_loop_lock_count),
    .lock_event  (ref_lock_event),
    .count_reg   (ref_cnt)
  );

  lock_counter #(.CW(CW), .WW(WW)) u_main_lock (
    .core_clk    (core_clk),
    .reset       (reset),
    .pd_event    (main_pd_event),
    .phase_error (main_phase_error),
    .window_size (main_loop_window_size),
    .lock_count  (main_loop_lock_count),
    .lock_event  (main_lock_event),
    .count_reg   (main_cnt)
  );

  lock_counter #(.CW(CW), .WW(WW)) u_exit_lock (
    .core_clk    (core_clk),
    .reset       (reset),
    .pd_event    (ref_pd_event),
    .phase_error (ref_phase_error),
    .window_size (ref_loop_window_size),
    .lock_count  (holdover_exit_count),
    .lock_event  (exit_event),
    .count_reg   (exit_cnt)
  );

  // Lock indicators rise on the lock event, drop on an outside edge pair
  always_ff @(posedge core_clk) begin
    if (reset) begin
      first_loop_lock <= 1'b0;
    end else if (ref_lock_event) begin
      first_loop_lock <= 1'b1;
    end else if (ref_pd_event && !(ref_phase_error < ref_loop_window_size)) begin
      first_loop_lock <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      second_loop_lock <= 1'b0;
    end else if (main_lock_event) begin
      second_loop_lock <= 1'b1;
    end else if (main_pd_event && !(main_phase_error < main_loop_window_size)) begin
      second_loop_lock <= 1'b0;
    end
  end

  // Holdover: exit event wins over an entry request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      holdover_state_flag <= 1'b0;
    end else if (exit_event) begin
      holdover_state_flag <= 1'b0;
    end else if (holdover_enter) begin
      holdover_state_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // DAC readback
  // ---------------------------------------------------------------
  logic [9:0] tuning_dac_readback;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tuning_dac_readback <= DAC_RESET;
    end else if (dac_update && first_loop_lock) begin
      tuning_dac_readback <= dac_value;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [7:0] rdata_next;

  // Read mux; key addresses and unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      OFS_INPUT_STATUS: begin
        rdata_next[7:DAC_HI_LSB]   = tuning_dac_readback[9:8];
        rdata_next[BIT_IN1_LOSS]   = in1_signal_loss_flag;
        rdata_next[BIT_IN0_LOSS]   = in0_signal_loss_flag;
      end
      OFS_DAC_LOW: begin
        rdata_next = tuning_dac_readback[7:0];
      end
      OFS_HOLDOVER: begin
        rdata_next[BIT_HOLDOVER] = holdover_state_flag;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Registered read data and completion of every transaction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= reg_wr || reg_rd;
      if (reg_rd) reg_rdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_locked_refuse: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && !regs_unlocked && !is_key_addr |=> !protected_wr)
    else $error("write passed while locked");
  a_write_acked: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr |=> reg_ack)
    else $error("write not completed");
  a_key_unreadable: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && is_key_addr |=> reg_rdata == 8'h00)
    else $error("key byte read back");
  a_unlock_value: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && reg_addr == OFS_KEY_LOW && reg_wdata != KEY_LOW_OPEN |=> !regs_unlocked)
    else $error("unlock with wrong key");
  a_loss_bit_one: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && reg_addr == OFS_INPUT_STATUS |=> reg_rdata[1] == $past(in1_signal_loss_flag))
    else $error("loss bit one wrong");
  a_loss_bit_zero: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && reg_addr == OFS_INPUT_STATUS |=> reg_rdata[0] == $past(in0_signal_loss_flag) && !reg_rdata[2])
    else $error("loss bit zero wrong");
  a_holdover_read: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && reg_addr == OFS_HOLDOVER |=> reg_rdata == {3'h0, $past(holdover_state_flag), 4'h0})
    else $error("holdover read wrong");
  a_exit_holdover: assert property (@(posedge core_clk) disable iff (reset)
    exit_event |=> !holdover_state_flag)
    else $error("holdover not left");
  a_lock_raise: assert property (@(posedge core_clk) disable iff (reset)
    main_lock_event |=> second_loop_lock)
    else $error("lock indicator not raised");

  // Counting, readback hold and pass-through of open writes
  a_ref_lock_raise: assert property (@(posedge core_clk) disable iff (reset)
    ref_lock_event |=> first_loop_lock)
    else $error("first loop indicator not raised");
  a_ref_count_step: assert property (@(posedge core_clk) disable iff (reset)
    ref_pd_event && (ref_phase_error < ref_loop_window_size) && ref_cnt != '1
    |=> ref_cnt == $past(ref_cnt) + 1'b1)
    else $error("first loop count not advanced");
  a_main_count_step: assert property (@(posedge core_clk) disable iff (reset)
    main_pd_event && (main_phase_error < main_loop_window_size) && main_cnt != '1
    |=> main_cnt == $past(main_cnt) + 1'b1)
    else $error("second loop count not advanced");
  a_exit_count_clear: assert property (@(posedge core_clk) disable iff (reset)
    ref_pd_event && !(ref_phase_error < ref_loop_window_size) |=> exit_cnt == '0 && ref_cnt == '0)
    else $error("exit count not cleared");
  a_dac_hold_unlocked: assert property (@(posedge core_clk) disable iff (reset)
    !first_loop_lock |=> tuning_dac_readback == $past(tuning_dac_readback))
    else $error("dac readback moved without lock");
  a_open_write_pass: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && regs_unlocked && !is_key_addr |=> protected_wr && protected_addr == $past(reg_addr))
    else $error("open write not passed on");
  a_read_acked: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd |=> reg_ack)
    else $error("read not completed");
  a_high_byte_lock: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && reg_addr == OFS_KEY_HIGH && reg_wdata != 8'h00 |=> !regs_unlocked)
    else $error("nonzero high key byte left bank open");
endmodule
`default_nettype wire

/* host_model.sv */
// Host controller model for the register strobe port
`timescale 1ns/10ps
`default_nettype none
module host_model
  import lock_status_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reg_ack,
  input  wire logic [7:0]        reg_rdata,
  output var logic               reg_wr,
  output var logic               reg_rd,
  output var logic [ADDR_W-1:0]  reg_addr,
  output var logic [7:0]         reg_wdata
);
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
  end

  // One access: strobe for one cycle, then wait a bounded time for the ack
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 8'h00;
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    while (!ok && n < 8) begin
      @(posedge core_clk);
      ok = (reg_ack === 1'b1);
      n++;
    end
    q = reg_rdata;
    // Stale address and data do not linger after the answer
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Key bytes always go out high, middle, low in turn
  task automatic write_key(input logic [23:0] k, output logic ok);
    logic [7:0] q;
    logic       o1, o2, o3;
    access(1'b1, OFS_KEY_HIGH, k[23:16], q, o1);
    access(1'b1, OFS_KEY_MID, k[15:8], q, o2);
    access(1'b1, OFS_KEY_LOW, k[7:0], q, o3);
    ok = o1 & o2 & o3;
  endtask
endmodule
`default_nettype wire

/* tb_lock_status_and_write_protect.sv */
// Self-checking testbench for the lock status and write protect block
`timescale 1ns/10ps
`default_nettype none
module tb_lock_status_and_write_protect
  import lock_status_pkg::*;
;
  logic core_clk, reset, reg_wr, reg_rd, reg_ack, wr_accept, regs_unlocked;
  logic [ADDR_W-1:0] reg_addr, protected_addr;
  logic [7:0] reg_wdata, reg_rdata, protected_wdata, ref_win, main_win, b;
  logic in0, in1, ref_pd, main_pd, hold_enter, dac_upd, first_lock, second_lock, hold_flag, protected_wr;
  logic [7:0] ref_err, main_err;
  logic [15:0] ref_n, main_n, hold_n;
  logic [9:0] dac_v;
  int err_count, check_count, streak, i;
  logic hold;
  logic acc_seen;

  host_model host (.core_clk(core_clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  lock_status_top DUT (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .wr_accept(wr_accept), .regs_unlocked(regs_unlocked), .in0_signal_loss_pin(in0),
    .in1_signal_loss_pin(in1), .ref_pd_event(ref_pd), .ref_phase_error(ref_err),
    .main_pd_event(main_pd), .main_phase_error(main_err), .ref_loop_window_size(ref_win),
    .ref_loop_lock_count(ref_n), .main_loop_window_size(main_win), .main_loop_lock_count(main_n),
    .holdover_exit_count(hold_n), .holdover_enter(hold_enter), .dac_update(dac_upd),
    .dac_value(dac_v), .first_loop_lock(first_lock), .second_loop_lock(second_lock),
    .holdover_state_flag(hold_flag), .protected_wr(protected_wr), .protected_wdata(protected_wdata),
    .protected_addr(protected_addr));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Acceptance level captured with each write strobe
  always @(posedge core_clk) begin
    if (reg_wr) acc_seen <= wr_accept;
  end

  // Expected clock input status byte
  function automatic logic [7:0] status_byte(input logic [9:0] v, input logic l1, input logic l0);
    return {v[9:8], 4'h0, l1, l0};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // A missing answer ends the run
  task automatic ackd(input logic ok);
    chk(16'(ok), 16'h0001);
    if (ok !== 1'b1) stop_test();
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       ok;
    host.access(1'b0, a, 8'h00, q, ok);
    ackd(ok);
    chk(16'(q), 16'(e));
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic pw);
    logic [7:0] q;
    logic       ok;
    host.access(1'b1, a, d, q, ok);
    ackd(ok);
    chk(16'(acc_seen), 16'(pw));
    chk(16'(protected_wr), 16'(pw));
    if (pw) chk(16'(protected_addr), 16'(a));
    if (pw) chk(16'(protected_wdata), 16'(d));
  endtask

  // Program a key, then try a plain write that only an open bank lets through
  task automatic key(input logic [23:0] k, input logic e);
    logic ok;
    host.write_key(k, ok);
    ackd(ok);
    chk(16'(regs_unlocked), 16'(e));
    wr(13'($urandom_range(13'h0fff, 13'h0200)), 8'($urandom), e);
  endtask

  // One compare on both loops, good means inside the window
  task automatic pd(input logic good);
    @(posedge core_clk);
    ref_pd <= 1'b1;
    main_pd <= 1'b1;
    ref_err <= good ? 8'($urandom_range(ref_win - 1)) : ref_win;
    main_err <= good ? 8'($urandom_range(main_win - 1)) : main_win;
    streak = good ? streak + 1 : 0;
    if (streak >= hold_n) hold = 1'b0;
    @(posedge core_clk);
    ref_pd <= 1'b0;
    main_pd <= 1'b0;
    @(posedge core_clk);
    chk(16'(first_lock), 16'(streak >= ref_n));
    chk(16'(second_lock), 16'(streak >= main_n));
    chk(16'(hold_flag), 16'(hold));
  endtask

  initial begin
    void'($urandom(32'he3b5));
    {reset, in0, in1, ref_pd, main_pd, hold_enter, dac_upd} = 7'h40;
    {ref_err, main_err, dac_v} = '0;
    ref_win = 8'd4 + 8'($urandom_range(20));
    main_win = 8'd4 + 8'($urandom_range(20));
    ref_n = 16'h0005;
    main_n = 16'h0003;
    hold_n = 16'h0004;
    err_count = 0;
    check_count = 0;
    streak = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd(OFS_DAC_LOW, 8'h00);
    rd(OFS_INPUT_STATUS, status_byte(DAC_RESET, 1'b0, 1'b0));
    rd(OFS_HOLDOVER, 8'h00);
    rd(OFS_KEY_LOW, 8'h00);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      in0 <= i[0];
      in1 <= i[1];
      repeat (3) @(posedge core_clk);
      rd(OFS_INPUT_STATUS, status_byte(DAC_RESET, i[1], i[0]));
    end
    b = 8'($urandom_range(255, 1));
    wr(13'h0100, 8'h5a, 1'b1);
    key({b, 8'h00, KEY_LOW_OPEN}, 1'b0);
    key({8'h00, b, KEY_LOW_OPEN}, 1'b0);
    key({16'h0000, 8'($urandom_range(82))}, 1'b0);
    key({16'h0000, 8'($urandom_range(255, 84))}, 1'b0);
    key({16'h0000, 8'h52}, 1'b0);
    key({KEY_HIGH_RESET, KEY_MID_RESET, KEY_LOW_OPEN}, 1'b1);
    @(posedge core_clk);
    hold_enter <= 1'b1;
    dac_upd <= 1'b1;
    dac_v <= 10'($urandom);
    @(posedge core_clk);
    hold_enter <= 1'b0;
    dac_upd <= 1'b0;
    hold = 1'b1;
    rd(OFS_HOLDOVER, 8'h10);
    rd(OFS_DAC_LOW, 8'h00);
    for (i = 0; i < 8; i++) pd(i != 2);
    @(posedge core_clk);
    dac_upd <= 1'b1;
    dac_v <= 10'($urandom);
    @(posedge core_clk);
    dac_upd <= 1'b0;
    rd(OFS_DAC_LOW, dac_v[7:0]);
    rd(OFS_INPUT_STATUS, status_byte(dac_v, 1'b1, 1'b1));
    rd(OFS_HOLDOVER, 8'h00);
    pd(1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
